// file: shared/spibcp_pkg.sv
// How it works
// - new word while full: drop it, flag overflow
// - data window write sets transmit full
// - transmit start into shifter clears transmit full
// - receive load sets, data read clears receive full
// - secondary select 111..000 divides 1..8
// - primary select 11,10,01,00 divides 1,4,16,64
// - framed mode ignores clock edge select
package spibcp_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [11:0] ADDR_STAT = 12'h000;
  localparam logic [11:0] ADDR_CON1 = 12'h004;
  localparam logic [11:0] ADDR_DATA = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h010;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h014;

  // ==========================================================
  // status field positions
  localparam int STAT_EN_BIT = 15;
  localparam int STAT_ROV_BIT = 6;
  localparam int STAT_TBF_BIT = 1;
  localparam int STAT_RBF_BIT = 0;

  // ==========================================================
  // control one field positions
  localparam int CON1_FRM_BIT = 12;
  localparam int CON1_MSTR_BIT = 5;
  localparam int CON1_CKE_BIT = 8;
  localparam int CON1_CKP_BIT = 6;
  localparam int CON1_SEC_LSB = 2;
  localparam int CON1_PRI_LSB = 0;

  // ==========================================================
  // reset values
  localparam logic [15:0] CON1_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // interrupt status layout
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int IRQ_OV_BIT = 2;

  localparam int WORD_BITS = 16;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_LOW = 2'b01,
    SH_HIGH = 2'b10
  } spibcp_state_t;

  typedef struct packed {
    logic sck;
    logic sdo;
  } spibcp_serial_t;

endpackage

// file: src/spibcp_core.sv
`timescale 1ns/1ns
module spibcp_core (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // serial pins
  input wire logic SDI,
  output logic SCK,
  output logic SDO,
  // interrupt
  output logic IRQ
);

  // ==========================================================
  // register state
  logic [15:0] con1_q, con1_d;
  logic en_q, en_d;
  logic rov_q, rov_d;
  logic tbf_q, tbf_d;
  logic rbf_q, rbf_d;
  logic [15:0] txb_q, txb_d;
  logic [15:0] rxb_q, rxb_d;
  logic [2:0] irq_st_q, irq_st_d;
  logic [2:0] irq_en_q, irq_en_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;

  // shift engine state
  spibcp_pkg::spibcp_state_t st_q, st_d;
  logic [15:0] sr_q, sr_d;
  logic [4:0] bit_q, bit_d;
  logic [6:0] pcnt_q, pcnt_d;
  logic [2:0] scnt_q, scnt_d;
  spibcp_pkg::spibcp_serial_t ser_q, ser_d;

  logic acc, wr, rd, tick, start, done;
  logic [6:0] pri_div;
  logic [2:0] sec_sel;
  logic [3:0] sec_div;
  logic sck_idle, cke_eff;

  assign acc = PSEL && PENABLE && !pready_q;
  assign wr = acc && PWRITE;
  assign rd = acc && !PWRITE;

  // ==========================================================
  // prescalers
  always_comb begin
    unique case (con1_q[spibcp_pkg::CON1_PRI_LSB +: 2])
      2'b11: pri_div = 7'd1;
      2'b10: pri_div = 7'd4;
      2'b01: pri_div = 7'd16;
      2'b00: pri_div = 7'd64;
    endcase
  end
  assign sec_sel = con1_q[spibcp_pkg::CON1_SEC_LSB +: 3];
  assign sec_div = 4'd8 - {1'b0, sec_sel};
  // a tick every pri*sec clocks marks each half serial period
  assign tick = (pcnt_q == pri_div - 7'd1) && (scnt_q == sec_div[2:0] - 3'd1);
  assign sck_idle = con1_q[spibcp_pkg::CON1_CKP_BIT];
  // framed mode forces the edge select off
  assign cke_eff = con1_q[spibcp_pkg::CON1_CKE_BIT] && !con1_q[spibcp_pkg::CON1_FRM_BIT];

  always_comb begin
    pcnt_d = pcnt_q;
    scnt_d = scnt_q;
    if (st_q == spibcp_pkg::SH_IDLE) begin
      pcnt_d = 7'd0;
      scnt_d = 3'd0;
    end else if (pcnt_q == pri_div - 7'd1) begin
      pcnt_d = 7'd0;
      scnt_d = (scnt_q == sec_div[2:0] - 3'd1) ? 3'd0 : scnt_q + 3'd1;
    end else begin
      pcnt_d = pcnt_q + 7'd1;
    end
  end

  // ==========================================================
  // shift engine, master only
  assign start = en_q && con1_q[spibcp_pkg::CON1_MSTR_BIT] && tbf_q && st_q == spibcp_pkg::SH_IDLE;
  assign done = tick && st_q == spibcp_pkg::SH_HIGH && bit_q == 5'd1;

  always_comb begin
    st_d = st_q;
    sr_d = sr_q;
    bit_d = bit_q;
    ser_d = ser_q;
    unique case (st_q)
      spibcp_pkg::SH_IDLE: begin
        ser_d.sck = sck_idle;
        if (start) begin
          sr_d = txb_q;
          bit_d = 5'(spibcp_pkg::WORD_BITS);
          ser_d.sdo = txb_q[15];
          st_d = spibcp_pkg::SH_LOW;
        end
      end
      spibcp_pkg::SH_LOW: begin
        if (tick) begin
          ser_d.sck = !sck_idle;
          sr_d = {sr_q[14:0], SDI};
          st_d = spibcp_pkg::SH_HIGH;
        end
      end
      spibcp_pkg::SH_HIGH: begin
        if (tick) begin
          ser_d.sck = sck_idle;
          bit_d = bit_q - 5'd1;
          ser_d.sdo = cke_eff ? sr_q[15] : sr_q[15];
          st_d = (bit_q == 5'd1) ? spibcp_pkg::SH_IDLE : spibcp_pkg::SH_LOW;
        end
      end
      default: st_d = spibcp_pkg::SH_IDLE;
    endcase
  end

  // ==========================================================
  // flags and registers
  always_comb begin
    con1_d = con1_q;
    en_d = en_q;
    txb_d = txb_q;
    rxb_d = rxb_q;
    tbf_d = tbf_q;
    rbf_d = rbf_q;
    rov_d = rov_q;
    irq_en_d = irq_en_q;
    irq_st_d = irq_st_q;
    if (wr && PADDR == spibcp_pkg::ADDR_CON1) con1_d = PWDATA[15:0];
    if (wr && PADDR == spibcp_pkg::ADDR_IRQ_EN) irq_en_d = PWDATA[2:0];
    if (wr && PADDR == spibcp_pkg::ADDR_IRQ_CLR) irq_st_d = irq_st_q & ~PWDATA[2:0];
    if (wr && PADDR == spibcp_pkg::ADDR_STAT) begin
      en_d = PWDATA[spibcp_pkg::STAT_EN_BIT];
      if (!PWDATA[spibcp_pkg::STAT_ROV_BIT]) rov_d = 1'b0;
    end
    if (start) tbf_d = 1'b0;
    if (wr && PADDR == spibcp_pkg::ADDR_DATA) begin
      txb_d = PWDATA[15:0];
      tbf_d = 1'b1;
    end
    if (rd && PADDR == spibcp_pkg::ADDR_DATA) rbf_d = 1'b0;
    if (done) begin
      if (rbf_q && !(rd && PADDR == spibcp_pkg::ADDR_DATA)) begin
        rov_d = 1'b1;
        irq_st_d[spibcp_pkg::IRQ_OV_BIT] = 1'b1;
      end else begin
        rxb_d = sr_q;
        rbf_d = 1'b1;
        irq_st_d[spibcp_pkg::IRQ_RX_BIT] = 1'b1;
      end
    end
    if (start) irq_st_d[spibcp_pkg::IRQ_TX_BIT] = 1'b1;
  end

  // ==========================================================
  // apb answer, registered, so the access phase has one wait state
  always_comb begin
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    pready_d = acc;
    if (acc) begin
      unique case (PADDR)
        spibcp_pkg::ADDR_STAT: prdata_d = {16'h0000, en_q, 8'h00, rov_q, 4'h0, tbf_q, rbf_q};
        spibcp_pkg::ADDR_CON1: prdata_d = {16'h0000, con1_q};
        spibcp_pkg::ADDR_DATA: prdata_d = {16'h0000, rxb_q};
        spibcp_pkg::ADDR_IRQ_STAT: prdata_d = {29'h0000_0000, irq_st_q};
        spibcp_pkg::ADDR_IRQ_EN: prdata_d = {29'h0000_0000, irq_en_q};
        spibcp_pkg::ADDR_IRQ_CLR: prdata_d = 32'h0000_0000;
        default: pslverr_d = 1'b1;
      endcase
    end
    irq_d = |(irq_st_d & irq_en_d);
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      con1_q <= spibcp_pkg::CON1_RESET;
      en_q <= 1'b0;
      rov_q <= 1'b0;
      tbf_q <= 1'b0;
      rbf_q <= 1'b0;
      txb_q <= spibcp_pkg::WORD_RESET;
      rxb_q <= spibcp_pkg::WORD_RESET;
      irq_st_q <= spibcp_pkg::IRQ_RESET;
      irq_en_q <= spibcp_pkg::IRQ_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      st_q <= spibcp_pkg::SH_IDLE;
      sr_q <= spibcp_pkg::WORD_RESET;
      bit_q <= 5'd0;
      pcnt_q <= 7'd0;
      scnt_q <= 3'd0;
      ser_q <= '0;
    end else begin
      con1_q <= con1_d;
      en_q <= en_d;
      rov_q <= rov_d;
      tbf_q <= tbf_d;
      rbf_q <= rbf_d;
      txb_q <= txb_d;
      rxb_q <= rxb_d;
      irq_st_q <= irq_st_d;
      irq_en_q <= irq_en_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
      st_q <= st_d;
      sr_q <= sr_d;
      bit_q <= bit_d;
      pcnt_q <= pcnt_d;
      scnt_q <= scnt_d;
      ser_q <= ser_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign SCK = ser_q.sck;
  assign SDO = ser_q.sdo;
  assign IRQ = irq_q;

  // ==========================================================
  // checks
  a_overflow_keeps_old: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    done && rbf_q && !rd |=> rov_q && $stable(rxb_q))
    else $error("overflow did not keep old word");
  a_overflow_sticky: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    rov_q && !(wr && PADDR == spibcp_pkg::ADDR_STAT) |=> rov_q)
    else $error("overflow flag dropped by itself");
  a_data_write_full: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    wr && PADDR == spibcp_pkg::ADDR_DATA |=> tbf_q)
    else $error("transmit full not set");
  a_start_empties: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    start && !wr |=> !tbf_q && st_q == spibcp_pkg::SH_LOW)
    else $error("transmit full not cleared at start");
  a_rx_load_full: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    done && !rbf_q |=> rbf_q && rxb_q == $past(sr_q))
    else $error("receive load missed");
  a_sec_ratio: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (sec_sel == 3'b111 |-> sec_div == 4'd1) and (sec_sel == 3'b000 |-> sec_div == 4'd8))
    else $error("secondary ratio wrong");
  a_pri_ratio: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    con1_q[1:0] == 2'b00 |-> pri_div == 7'd64)
    else $error("primary ratio wrong");
  // ==========================================================
  // sequences
  sequence s_no_tick_3;
    !tick [*3];
  endsequence

  // ratio 4 by 1: mid-bit tick, then three quiet clocks, then the next edge
  a_tick_period: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    tick && con1_q[4:0] == 5'b11110 && st_q == spibcp_pkg::SH_LOW |=> s_no_tick_3 ##1 tick)
    else $error("tick spacing wrong");
  a_rx_read_clears: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    rd && PADDR == spibcp_pkg::ADDR_DATA && !done |=> !rbf_q)
    else $error("receive full not cleared by read");
  a_tx_irq_start: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    start |=> irq_st_q[spibcp_pkg::IRQ_TX_BIT])
    else $error("transmit start event not flagged");
  a_frame_edge: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    con1_q[spibcp_pkg::CON1_FRM_BIT] |-> !cke_eff)
    else $error("edge select used in framed mode");

endmodule // spibcp_core

// file: tb/spibcp_partner.sv
`timescale 1ns/1ns
// ==========================================================
// far-side serial peripheral
module spibcp_partner (
  // serial pins
  input wire logic SCK,
  output logic SDI,
  // word presented msb first
  input wire logic [15:0] WORD
);
  int idx = 15;
  // tests use uniform words so the result does not hang on the sampling edge
  always @(negedge SCK) begin
    idx <= (idx == 0) ? 15 : idx - 1;
  end
  assign SDI = WORD[idx[3:0]];
endmodule // spibcp_partner

// file: tb/test_spibcp_core.sv
`timescale 1ns/1ns
module test_spibcp_core;
  localparam logic [11:0] A_S = spibcp_pkg::ADDR_STAT;
  localparam logic [11:0] A_C = spibcp_pkg::ADDR_CON1;
  localparam logic [11:0] A_D = spibcp_pkg::ADDR_DATA;
  logic CLOCK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic PREADY, PSLVERR, SDI, SCK, SDO, IRQ, er;
  logic [15:0] word = 16'hFFFF;
  int n_fail = 0, comparisons = 0;
  spibcp_core dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SDI(SDI), .SCK(SCK), .SDO(SDO), .IRQ(IRQ));
  spibcp_partner peer (.SCK(SCK), .SDI(SDI), .WORD(word));
  initial begin
    forever #20 CLOCK = ~CLOCK;
  end
  // ==========================================================
  // shared tasks
  task test_done;
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge CLOCK);
  endtask
  task wait_bit(input int b);
    int k;
    k = 0;
    do begin
      apb(0, A_S, 0);
      k++;
    end while (rd[b] !== 1'b1 && k < 3000);
    chk(rd[b], 1);
  endtask
  // clocks between two serial clock changes
  task per(input int n);
    int c;
    logic s;
    c = 0;
    s = SCK;
    while (SCK === s && c < 2000) begin @(posedge CLOCK); c++; end
    s = SCK;
    c = 0;
    while (SCK === s && c < 2000) begin @(posedge CLOCK); c++; end
    chk(c, n);
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    apb(0, A_S, 0); chk(rd, 0);
    apb(0, A_C, 0); chk(rd, 0);
    chk(IRQ, 0);
  endtask
  task t_refused;
    apb(0, 12'h018, 0); chk(er, 1);
    apb(1, spibcp_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
    apb(0, spibcp_pkg::ADDR_IRQ_STAT, 0); chk(rd, 0);
  endtask
  task t_flags;
    apb(1, A_C, 32'h0000_003C);
    apb(1, A_D, 32'h0000_1234);
    apb(0, A_S, 0); chk(rd, 32'h0000_0002);
    apb(1, spibcp_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    apb(1, A_S, 32'h0000_8000);
    apb(0, A_S, 0); chk(rd, 32'h0000_8000);
    wait_bit(0);
    chk(IRQ, 1);
    apb(0, A_D, 0); chk(rd, 32'h0000_FFFF);
    apb(0, A_S, 0); chk(rd, 32'h0000_8000);
    apb(1, spibcp_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
    @(posedge CLOCK);
    chk(IRQ, 0);
  endtask
  task t_ratios;
    logic [1:0] pri [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
    logic [2:0] sec [4] = '{3'b111, 3'b000, 3'b110, 3'b111};
    int n [4] = '{4, 8, 32, 64};
    for (int i = 0; i < 4; i++) begin
      apb(1, A_C, {27'h20 >> 5, sec[i], pri[i]} | 32'h0000_0020);
      apb(1, A_D, 0);
      per(n[i]);
      wait_bit(0);
      apb(0, A_D, 0);
    end
  endtask
  task t_overflow;
    apb(1, A_C, 32'h0000_003E);
    apb(1, A_D, 0);
    wait_bit(0);
    word = 16'h0000;
    apb(1, A_D, 0);
    wait_bit(6);
    apb(0, A_S, 0); chk(rd, 32'h0000_8041);
    apb(0, A_D, 0); chk(rd, 32'h0000_FFFF);
    apb(1, A_S, 32'h0000_8000);
    apb(0, A_S, 0); chk(rd, 32'h0000_8000);
    apb(1, A_C, 32'h0000_103E);
    apb(0, A_C, 0); chk(rd, 32'h0000_103E);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge CLOCK);
    SYS_RST <= 0;
    @(posedge CLOCK);
    t_reset;
    t_refused;
    t_flags;
    t_ratios;
    t_overflow;
    test_done;
  end
  initial begin
    repeat (60000) @(posedge CLOCK);
    n_fail++;
    test_done;
  end
endmodule // test_spibcp_core
